/* File: src/iosr_consts.svh */
// constants for the instrument operation status registers
// Notes on behaviour
// - top condition register shows operations running right now.
// - top event register records operations since last read; read clears it.
// - top bit 0 high while any channel calibrates.
// - top bit 4 high while any channel measures.
// - top bit 5 high while any channel awaits a trigger.
// - top bit 10 high while any channel initializes.
// - top bit 11 high when a result is below its lower limit.
// - top bit 12 high when a result is above its upper limit.
// - bit 15 never used; top bits 1-3, 6-9, 13-14 unassigned.
// - calibrating bits 1-4 follow channels A-D; others unused.
// - calibrating events record start and/or end as edge selects choose.
// - measuring bits 1-4 follow channels A-D; others unused.
// - measuring events record start and/or completion as edge selects choose.
// - trigger-wait bits 1-4 follow channels A-D awaiting a trigger.
// - trigger-wait events record entry and/or exit as edge selects choose.
// - initializing bits 1-4 follow channels A-D; others unused.
// - initializing events record start and/or completion as edge selects choose.
// - channel initializes at power-up, on attach, and on reset or preset.
// - event bit sets on condition edges its edge selects enable; top bits 0, 4, 5, 10 also set on any new event of their sub-register.
`ifndef IOSR_CONSTS_SVH
`define IOSR_CONSTS_SVH

`define IOSR_W         16
`define IOSR_CH        4
`define IOSR_NUNIT     5
`define IOSR_U_TOP     3'h0
`define IOSR_U_CAL     3'h1
`define IOSR_U_MEAS    3'h2
`define IOSR_U_TRIG    3'h3
`define IOSR_U_INIT    3'h4
`define IOSR_B_CAL     0
`define IOSR_B_MEAS    4
`define IOSR_B_TRIG    5
`define IOSR_B_INIT    10
`define IOSR_B_LLIM    11
`define IOSR_B_ULIM    12
`define IOSR_SUB_LSB   1
`define IOSR_SUB_MASK  16'h001e
`define IOSR_TOP_MASK  16'h1c31
`define IOSR_RISE_RST  16'h7fff
`define IOSR_FALL_RST  16'h0000
// query/config address: [4] edge-select space, [3:1] unit, [0] event / falling
`define IOSR_A_TRANS   4
`define IOSR_AW        5

`endif

/* File: src/iosr_pkg.sv */
// types for the instrument operation status registers
package iosr_pkg;
	typedef struct packed {
		logic [3:0] calibrating;
		logic [3:0] measuring;
		logic [3:0] awaiting_trigger_state;
	} iosr_chan_t;

	typedef struct packed {
		logic       valid;
		logic [4:0] addr;
	} iosr_query_t;

	typedef struct packed {
		logic        valid;
		logic [4:0]  addr;
		logic [15:0] data;
	} iosr_cfg_t;
endpackage

/* File: src/iosr_status_unit.sv */
// one status register: condition, edge selects, read-clear event part
`timescale 1ns/1ps
`include "iosr_consts.svh"
module iosr_status_unit #(
	parameter logic [15:0] MASK = `IOSR_SUB_MASK
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        reset,
	// live state in
	input  wire logic [15:0] cond_in,
	input  wire logic [15:0] set_in,
	// edge selects
	input  wire logic [15:0] rising_edge_select,
	input  wire logic [15:0] falling_edge_select,
	// read side
	input  wire logic        clear,
	output logic      [15:0] cond,
	output logic      [15:0] event_bits,
	output logic      [15:0] new_set
);
	logic [15:0] live;

	assign live = cond_in & MASK;
	// selected edges and set_in reach the event part
	assign new_set = ((live & ~cond & rising_edge_select) |
		(~live & cond & falling_edge_select) | set_in) & MASK;

	always_ff @(posedge clk) begin
		if (reset) begin
			cond <= 16'h0000;
		end else begin
			cond <= live;
		end
	end

	// set wins over the read clear so a coincident edge is not lost
	always_ff @(posedge clk) begin
		if (reset) begin
			event_bits <= 16'h0000;
		end else begin
			event_bits <= (clear ? 16'h0000 : event_bits) | new_set;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	set_wins_a: assert property (clear && new_set != 16'h0000 |=> event_bits == $past(new_set))
		else $error("event set lost under read clear");
	read_clear_a: assert property (clear && new_set == 16'h0000 |=> event_bits == 16'h0000)
		else $error("event part not cleared by read");
	rise_only_a: assert property (($changed(event_bits) && !$past(clear)) |->
		(($past(event_bits) & ~event_bits) == 16'h0000))
		else $error("event bit dropped without a read");
	bit15_unit_a: assert property (!event_bits[15] && !cond[15])
		else $error("bit 15 used");
endmodule

/* File: src/iosr_top.sv */
// operation status register bank: top register and four per-channel sub-registers
`timescale 1ns/1ps
`include "iosr_consts.svh"
module iosr_top (
	// clock and reset
	input  wire logic                 clk,
	input  wire logic                 reset,
	// channel activity from the measuring engine
	input  wire iosr_pkg::iosr_chan_t chan,
	// sensor attach pins and initialization control
	input  wire logic [3:0]           sensor_present,
	input  wire logic                 preset_cmd,
	input  wire logic [3:0]           init_done,
	// limit-fail summaries
	input  wire logic                 lower_limit_fail,
	input  wire logic                 upper_limit_fail,
	// status query port
	input  wire iosr_pkg::iosr_query_t query,
	output logic                      query_ack,
	output logic [15:0]               query_data,
	// edge select configuration
	input  wire iosr_pkg::iosr_cfg_t  cfg
);
	logic [3:0]  pres_meta;
	logic [3:0]  pres_sync;
	logic [3:0]  pres_prev;
	logic [3:0]  init_flag;
	logic [3:0]  initializing;
	logic [15:0] unit_cond_in [`IOSR_NUNIT];
	logic [15:0] unit_set_in  [`IOSR_NUNIT];
	logic [15:0] unit_cond    [`IOSR_NUNIT];
	logic [15:0] unit_event   [`IOSR_NUNIT];
	logic [15:0] unit_new     [`IOSR_NUNIT];
	logic [15:0] rise_sel     [`IOSR_NUNIT];
	logic [15:0] fall_sel     [`IOSR_NUNIT];
	logic [`IOSR_NUNIT-1:0] unit_clear;
	logic [2:0]  q_unit;
	logic [2:0]  c_unit;
	logic [15:0] next_query_data;

	assign q_unit = query.addr[3:1];
	assign c_unit = cfg.addr[3:1];

	// attach pins come from outside the clock domain
	always_ff @(posedge clk) begin
		if (reset) begin
			pres_meta <= 4'h0;
			pres_sync <= 4'h0;
			pres_prev <= 4'h0;
		end else begin
			pres_meta <= sensor_present;
			pres_sync <= pres_meta;
			pres_prev <= pres_sync;
		end
	end

	// per-channel initializing state
	genvar c;
	generate
		for (c = 0; c < `IOSR_CH; c++) begin : g_init
			always_ff @(posedge clk) begin
				if (reset) begin
					init_flag[c] <= 1'b1;
				end else if (preset_cmd || (pres_sync[c] && !pres_prev[c])) begin
					init_flag[c] <= 1'b1;
				end else if (init_done[c]) begin
					init_flag[c] <= 1'b0;
				end
			end
			// an absent sensor cannot be initializing
			assign initializing[c] = init_flag[c] & pres_sync[c];
		end
	endgenerate

	// condition inputs of every unit
	always_comb begin
		unit_cond_in[`IOSR_U_CAL]  = {11'h000, chan.calibrating, 1'b0};
		unit_cond_in[`IOSR_U_MEAS] = {11'h000, chan.measuring, 1'b0};
		unit_cond_in[`IOSR_U_TRIG] = {11'h000, chan.awaiting_trigger_state, 1'b0};
		unit_cond_in[`IOSR_U_INIT] = {11'h000, initializing, 1'b0};
		unit_cond_in[`IOSR_U_TOP]  = 16'h0000;
		unit_cond_in[`IOSR_U_TOP][`IOSR_B_CAL]  = |chan.calibrating;
		unit_cond_in[`IOSR_U_TOP][`IOSR_B_MEAS] = |chan.measuring;
		unit_cond_in[`IOSR_U_TOP][`IOSR_B_TRIG] = |chan.awaiting_trigger_state;
		unit_cond_in[`IOSR_U_TOP][`IOSR_B_INIT] = |initializing;
		unit_cond_in[`IOSR_U_TOP][`IOSR_B_LLIM] = lower_limit_fail;
		unit_cond_in[`IOSR_U_TOP][`IOSR_B_ULIM] = upper_limit_fail;
	end

	// summary events: a new sub-register event latches its top bit too
	always_comb begin
		unit_set_in[`IOSR_U_CAL]  = 16'h0000;
		unit_set_in[`IOSR_U_MEAS] = 16'h0000;
		unit_set_in[`IOSR_U_TRIG] = 16'h0000;
		unit_set_in[`IOSR_U_INIT] = 16'h0000;
		unit_set_in[`IOSR_U_TOP]  = 16'h0000;
		unit_set_in[`IOSR_U_TOP][`IOSR_B_CAL]  = |unit_new[`IOSR_U_CAL];
		unit_set_in[`IOSR_U_TOP][`IOSR_B_MEAS] = |unit_new[`IOSR_U_MEAS];
		unit_set_in[`IOSR_U_TOP][`IOSR_B_TRIG] = |unit_new[`IOSR_U_TRIG];
		unit_set_in[`IOSR_U_TOP][`IOSR_B_INIT] = |unit_new[`IOSR_U_INIT];
	end

	// status units, edge selects and read clears
	genvar u;
	generate
		for (u = 0; u < `IOSR_NUNIT; u++) begin : g_unit
			localparam logic [15:0] UMASK = (u == 0) ? `IOSR_TOP_MASK : `IOSR_SUB_MASK;

			always_ff @(posedge clk) begin
				if (reset) begin
					rise_sel[u] <= `IOSR_RISE_RST;
					fall_sel[u] <= `IOSR_FALL_RST;
				end else if (cfg.valid && cfg.addr[`IOSR_A_TRANS] && c_unit == 3'(u)) begin
					if (cfg.addr[0]) begin
						fall_sel[u] <= cfg.data & UMASK;
					end else begin
						rise_sel[u] <= cfg.data & UMASK;
					end
				end
			end

			// reading the event part empties it
			assign unit_clear[u] = query.valid && !query.addr[`IOSR_A_TRANS] &&
				query.addr[0] && q_unit == 3'(u);

			iosr_status_unit #(
				.MASK(UMASK)
			) u_stat (
				.clk                (clk),
				.reset              (reset),
				.cond_in            (unit_cond_in[u]),
				.set_in             (unit_set_in[u]),
				.rising_edge_select (rise_sel[u]),
				.falling_edge_select(fall_sel[u]),
				.clear              (unit_clear[u]),
				.cond               (unit_cond[u]),
				.event_bits         (unit_event[u]),
				.new_set            (unit_new[u])
			);
		end
	endgenerate

	// query read mux; unmapped addresses answer zero
	always_comb begin
		next_query_data = 16'h0000;
		if (q_unit < 3'(`IOSR_NUNIT)) begin
			case ({query.addr[`IOSR_A_TRANS], query.addr[0]})
				2'b00:   next_query_data = unit_cond[q_unit];
				2'b01:   next_query_data = unit_event[q_unit];
				2'b10:   next_query_data = rise_sel[q_unit];
				2'b11:   next_query_data = fall_sel[q_unit];
				default: next_query_data = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			query_ack  <= 1'b0;
			query_data <= 16'h0000;
		end else begin
			query_ack <= query.valid;
			if (query.valid) begin
				query_data <= next_query_data & 16'h7fff;
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	cal_summary_a: assert property (unit_cond[0][0] == $past(|chan.calibrating))
		else $error("calibrating summary wrong");
	meas_summary_a: assert property (unit_cond[0][4] == $past(|chan.measuring))
		else $error("measuring summary wrong");
	trig_summary_a: assert property (unit_cond[0][5] == $past(|chan.awaiting_trigger_state))
		else $error("trigger summary wrong");
	init_summary_a: assert property (unit_cond[0][10] == $past(|initializing))
		else $error("initializing summary wrong");
	limit_bits_a: assert property (unit_cond[0][12:11] == $past({upper_limit_fail, lower_limit_fail}))
		else $error("limit bits wrong");
	meas_channels_a: assert property (unit_cond[2][4:1] == $past(chan.measuring))
		else $error("measuring channel bits wrong");
	cal_channels_a: assert property (unit_cond[1][4:1] == $past(chan.calibrating))
		else $error("calibrating channel bits wrong");
	trig_channels_a: assert property (unit_cond[3][4:1] == $past(chan.awaiting_trigger_state))
		else $error("trigger channel bits wrong");
	top_unused_a: assert property ((unit_cond[0] & ~16'h1c31) == 16'h0000)
		else $error("unassigned top bit set");
	preset_init_a: assert property (preset_cmd |=> init_flag == 4'hf ##1 unit_cond[4][4:1] == $past(pres_sync))
		else $error("preset did not start initialization");
	summary_event_a: assert property (|unit_new[2] |=> unit_event[0][4])
		else $error("measuring summary event missed");
	query_bit15_a: assert property (query_ack |-> !query_data[15])
		else $error("bit 15 read high");
	event_read_a: assert property (query.valid && query.addr == 5'h01 |=> query_ack
		&& query_data == ($past(unit_event[0]) & 16'h7fff))
		else $error("event read wrong");

	// per-channel and unused bits
	init_channels_a: assert property (unit_cond[4][4:1] == $past(initializing))
		else $error("initializing channel bits wrong");
	cal_unused_a: assert property ((unit_cond[1] & ~16'h001e) == 16'h0000)
		else $error("unused calibrating bit set");
	meas_unused_a: assert property ((unit_cond[2] & ~16'h001e) == 16'h0000)
		else $error("unused measuring bit set");
	trig_unused_a: assert property ((unit_cond[3] & ~16'h001e) == 16'h0000)
		else $error("unused trigger bit set");
	init_unused_a: assert property ((unit_cond[4] & ~16'h001e) == 16'h0000)
		else $error("unused initializing bit set");
	top_ev_unused_a: assert property ((unit_event[0] & ~16'h1c31) == 16'h0000)
		else $error("unassigned top event bit set");
	cal_ev_unused_a: assert property ((unit_event[1] & ~16'h001e) == 16'h0000)
		else $error("unused calibrating event bit set");
	meas_ev_unused_a: assert property ((unit_event[2] & ~16'h001e) == 16'h0000)
		else $error("unused measuring event bit set");
	trig_ev_unused_a: assert property ((unit_event[3] & ~16'h001e) == 16'h0000)
		else $error("unused trigger event bit set");
	init_ev_unused_a: assert property ((unit_event[4] & ~16'h001e) == 16'h0000)
		else $error("unused initializing event bit set");

	// a fresh attach restarts only that channel
	attach_init_a: assert property ((pres_sync & ~pres_prev) != 4'h0 |=>
		(init_flag & $past(pres_sync & ~pres_prev)) == $past(pres_sync & ~pres_prev))
		else $error("attach did not start initialization");
	init_end_a: assert property (init_done != 4'h0 && !preset_cmd && (pres_sync & ~pres_prev) == 4'h0 |=>
		(init_flag & $past(init_done)) == 4'h0)
		else $error("initialization did not end");

	// query port: answer one cycle later, data held between queries
	ack_follows_a: assert property (query.valid |=> query_ack)
		else $error("query not answered");
	no_stray_ack_a: assert property (!query.valid |=> !query_ack)
		else $error("answer without query");
	data_hold_a: assert property (!query.valid |=> $stable(query_data))
		else $error("read data changed without query");
	top_cond_read_a: assert property (query.valid && query.addr == 5'h00 |=>
		query_data == ($past(unit_cond[0]) & 16'h7fff))
		else $error("top condition read wrong");
	cal_cond_read_a: assert property (query.valid && query.addr == 5'h02 |=>
		query_data == ($past(unit_cond[1]) & 16'h7fff))
		else $error("calibrating condition read wrong");
	cal_event_read_a: assert property (query.valid && query.addr == 5'h03 |=>
		query_data == ($past(unit_event[1]) & 16'h7fff))
		else $error("calibrating event read wrong");
	meas_cond_read_a: assert property (query.valid && query.addr == 5'h04 |=>
		query_data == ($past(unit_cond[2]) & 16'h7fff))
		else $error("measuring condition read wrong");
	meas_event_read_a: assert property (query.valid && query.addr == 5'h05 |=>
		query_data == ($past(unit_event[2]) & 16'h7fff))
		else $error("measuring event read wrong");
	trig_cond_read_a: assert property (query.valid && query.addr == 5'h06 |=>
		query_data == ($past(unit_cond[3]) & 16'h7fff))
		else $error("trigger condition read wrong");
	trig_event_read_a: assert property (query.valid && query.addr == 5'h07 |=>
		query_data == ($past(unit_event[3]) & 16'h7fff))
		else $error("trigger event read wrong");
	init_cond_read_a: assert property (query.valid && query.addr == 5'h08 |=>
		query_data == ($past(unit_cond[4]) & 16'h7fff))
		else $error("initializing condition read wrong");
	init_event_read_a: assert property (query.valid && query.addr == 5'h09 |=>
		query_data == ($past(unit_event[4]) & 16'h7fff))
		else $error("initializing event read wrong");
	top_rise_read_a: assert property (query.valid && query.addr == 5'h10 |=>
		query_data == ($past(rise_sel[0]) & 16'h7fff))
		else $error("top rising select read wrong");
	cal_fall_read_a: assert property (query.valid && query.addr == 5'h13 |=>
		query_data == ($past(fall_sel[1]) & 16'h7fff))
		else $error("calibrating falling select read wrong");
	meas_fall_read_a: assert property (query.valid && query.addr == 5'h15 |=>
		query_data == ($past(fall_sel[2]) & 16'h7fff))
		else $error("measuring falling select read wrong");
	trig_fall_read_a: assert property (query.valid && query.addr == 5'h17 |=>
		query_data == ($past(fall_sel[3]) & 16'h7fff))
		else $error("trigger falling select read wrong");
	unmapped_read_a: assert property (query.valid && !query.addr[4] && query.addr[3:1] > 3'h4 |=>
		query_data == 16'h0000)
		else $error("unmapped address read not zero");

	// edge-select writes keep only the bits their unit uses
	cal_fall_wr_a: assert property (cfg.valid && cfg.addr == 5'h13 |=>
		fall_sel[1] == ($past(cfg.data) & 16'h001e))
		else $error("calibrating falling select write wrong");
	meas_fall_wr_a: assert property (cfg.valid && cfg.addr == 5'h15 |=>
		fall_sel[2] == ($past(cfg.data) & 16'h001e))
		else $error("measuring falling select write wrong");
	trig_fall_wr_a: assert property (cfg.valid && cfg.addr == 5'h17 |=>
		fall_sel[3] == ($past(cfg.data) & 16'h001e))
		else $error("trigger falling select write wrong");
	sel_bit15_a: assert property ((rise_sel[0][15] | rise_sel[1][15] | rise_sel[2][15] |
		rise_sel[3][15] | rise_sel[4][15] | fall_sel[0][15] | fall_sel[1][15] |
		fall_sel[2][15] | fall_sel[3][15] | fall_sel[4][15]) == 1'b0)
		else $error("select bit 15 stored");
	clear_onehot_a: assert property ($onehot0(unit_clear))
		else $error("more than one event part cleared");

	low_limit_event_a: assert property ($rose(lower_limit_fail) && rise_sel[0][11] |=> unit_event[0][11])
		else $error("lower limit event missed");
	high_limit_event_a: assert property ($rose(upper_limit_fail) && rise_sel[0][12] |=> unit_event[0][12])
		else $error("upper limit event missed");
	cal_sum_event_a: assert property (|unit_new[1] |=> unit_event[0][0])
		else $error("calibrating summary event missed");
	trig_sum_event_a: assert property (|unit_new[3] |=> unit_event[0][5])
		else $error("trigger summary event missed");
	init_sum_event_a: assert property (|unit_new[4] |=> unit_event[0][10])
		else $error("initializing summary event missed");
endmodule

/* File: test/iosr_host_model.sv */
// host model: status queries and edge-select writes
`timescale 1ns/1ps
module iosr_host_model (
	// clock
	input  wire logic             clk,
	// requests to the device
	output iosr_pkg::iosr_query_t query,
	output iosr_pkg::iosr_cfg_t   cfg,
	// answer
	input  wire logic             query_ack,
	input  wire logic [15:0]      query_data
);
	initial begin
		query = '0;
		cfg = '0;
	end
	// valid is a one-cycle pulse; answer taken where ack is seen
	task automatic rd(input logic [4:0] a, output logic [15:0] d);
		int n;
		@(posedge clk);
		query <= '{valid: 1'b1, addr: a};
		@(posedge clk);
		query <= '{valid: 1'b0, addr: ~a};
		d = 'x;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (query_ack !== 1'b1 && n < 8);
		if (query_ack === 1'b1)
			d = query_data;
	endtask
	// idle fields inverted so a stale value is never mistaken for live
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk);
		cfg <= '{valid: 1'b1, addr: a, data: d};
		@(posedge clk);
		cfg <= '{valid: 1'b0, addr: ~a, data: ~d};
	endtask
endmodule

/* File: test/iosr_top_tb.sv */
// self-checking bench for the operation status register bank
`timescale 1ns/1ps
module iosr_top_tb;
	logic                  clk;
	logic                  reset;
	iosr_pkg::iosr_chan_t  chan;
	logic [3:0]            sensor_present;
	logic                  preset_cmd;
	logic [3:0]            init_done;
	logic                  lower_limit_fail;
	logic                  upper_limit_fail;
	iosr_pkg::iosr_query_t query;
	logic                  query_ack;
	logic [15:0]           query_data;
	iosr_pkg::iosr_cfg_t   cfg;
	int                    mismatches;
	int                    cmp_count;
	int                    tbit[3] = '{0, 4, 5};
	logic [4:0]            ua;
	logic [15:0]           tb;
	logic [15:0]           d;

	iosr_top dut_u (.clk(clk), .reset(reset), .chan(chan), .sensor_present(sensor_present),
		.preset_cmd(preset_cmd), .init_done(init_done), .lower_limit_fail(lower_limit_fail),
		.upper_limit_fail(upper_limit_fail), .query(query), .query_ack(query_ack),
		.query_data(query_data), .cfg(cfg));
	iosr_host_model host_u (.clk(clk), .query(query), .cfg(cfg), .query_ack(query_ack),
		.query_data(query_data));

	always #12.5 clk = ~clk;

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic rchk(input logic [4:0] a, input logic [15:0] exp);
		logic [15:0] v;
		host_u.rd(a, v);
		chk(v, exp);
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		repeat (5000) @(posedge clk);
		mismatches++;
		tally_and_finish;
	end

	initial begin
		clk = 0;
		reset = 1;
		chan = '0;
		sensor_present = '0;
		preset_cmd = 0;
		init_done = '0;
		lower_limit_fail = 0;
		upper_limit_fail = 0;
		repeat (5) @(posedge clk);
		reset <= 0;
		for (int u = 0; u < 5; u++) begin
			rchk({1'b1, u[2:0], 1'b0}, 16'h7fff);
			rchk({1'b1, u[2:0], 1'b1}, 16'h0000);
		end
		rchk(5'h0a, 16'h0000);
		rchk(5'h00, 16'h0000);
		$display("test reset_values done");
		for (int k = 0; k < 3; k++) begin
			ua = 5'(k + 1) << 1;
			tb = 16'h0001 << tbit[k];
			host_u.rd(5'h01, d);
			chan <= iosr_pkg::iosr_chan_t'(12'h009 << ((2 - k) * 4));
			repeat (3) @(posedge clk);
			rchk(ua, 16'h0012);
			rchk(ua + 5'h01, 16'h0012);
			rchk(ua + 5'h01, 16'h0000);
			rchk(5'h00, tb);
			rchk(5'h01, tb);
			host_u.wr(ua | 5'h11, 16'hffff);
			rchk(ua | 5'h11, 16'h001e);
			chan <= '0;
			repeat (3) @(posedge clk);
			rchk(ua, 16'h0000);
			rchk(ua + 5'h01, 16'h0012);
			rchk(5'h01, tb);
			$display("test channel_kind %0d done", k);
		end
		host_u.rd(5'h01, d);
		lower_limit_fail <= 1;
		repeat (3) @(posedge clk);
		rchk(5'h00, 16'h0800);
		rchk(5'h01, 16'h0800);
		upper_limit_fail <= 1;
		repeat (3) @(posedge clk);
		rchk(5'h00, 16'h1800);
		rchk(5'h01, 16'h1000);
		lower_limit_fail <= 0;
		upper_limit_fail <= 0;
		$display("test limits done");
		// sync of attach pins needs two edges before the flag shows
		sensor_present <= 4'b0011;
		repeat (4) @(posedge clk);
		rchk(5'h08, 16'h0006);
		rchk(5'h09, 16'h0006);
		rchk(5'h00, 16'h0400);
		init_done <= 4'b0001;
		@(posedge clk);
		init_done <= 4'b0000;
		rchk(5'h08, 16'h0004);
		preset_cmd <= 1;
		@(posedge clk);
		preset_cmd <= 0;
		rchk(5'h08, 16'h0006);
		init_done <= 4'b0011;
		@(posedge clk);
		init_done <= 4'b0000;
		sensor_present <= 4'b0111;
		repeat (4) @(posedge clk);
		rchk(5'h08, 16'h0008);
		$display("test initializing done");
		// device reset with sensors attached restarts their initialization
		reset <= 1;
		repeat (2) @(posedge clk);
		reset <= 0;
		repeat (4) @(posedge clk);
		rchk(5'h08, 16'h000e);
		rchk(5'h09, 16'h000e);
		rchk(5'h10, 16'h7fff);
		rchk(5'h13, 16'h0000);
		$display("test reset_restart done");
		tally_and_finish;
	end
endmodule
